// ---- core/gpio_reg8.sv ----
// Byte-lane writable 8-bit control register.
`timescale 1ns/1ns
module gpio_reg8 #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // Stored value
   output logic      [7:0] value_ff
);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         value_ff <= RESET_VALUE;
      end else if (wr_en) begin
         value_ff <= wr_data;
      end
   end

endmodule : gpio_reg8

// ---- core/spare_pin_cell.sv ----
// One multi-purpose pad: general-purpose drive or its normal function.
`timescale 1ns/1ns
module spare_pin_cell (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // General-purpose control
   input  wire logic gpio_en,
   input  wire logic gpio_val,
   // Normal pin function
   input  wire logic func_oe,
   input  wire logic func_out,
   // Pad
   input  wire logic pad_in,
   output logic      pad_out_ff,
   output logic      pad_oe_ff,
   // Sampled level
   output logic      level_ff
);

   logic nxt_pad_out;
   logic nxt_pad_oe;

   // General-purpose drive has priority over the pin function
   always_comb begin
      if (gpio_en) begin
         nxt_pad_oe  = 1'b1;
         nxt_pad_out = gpio_val;
      end else begin
         nxt_pad_oe  = func_oe;
         nxt_pad_out = func_oe & func_out;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pad_oe_ff  <= 1'b0;
         pad_out_ff <= 1'b0;
      end else begin
         pad_oe_ff  <= nxt_pad_oe;
         pad_out_ff <= nxt_pad_out;
      end
   end

   // Input buffer level is seen whether or not the pin drives
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         level_ff <= 1'b0;
      end else begin
         level_ff <= pad_in;
      end
   end

endmodule : spare_pin_cell

// ---- core/spare_pin_gpio_control.sv ----
// Spare pin general-purpose I/O with a classic Wishbone register slave.
`timescale 1ns/1ns
module spare_pin_gpio_control #(
   parameter int ADR_W = 12
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  wb_err_o,
   // Clock-output function from the clock generator
   input  wire logic             clock_out_fn,
   input  wire logic             clock_out_fn_en,
   // Boundary scan interface
   input  wire logic             scan_active,
   input  wire logic             scan_tdo,
   input  wire logic             scan_tdo_en,
   output logic                  scan_tck,
   output logic                  scan_tms,
   output logic                  scan_tdi,
   // Host interface select levels seen by the host interface logic
   output logic                  host_select_one_level,
   output logic                  host_select_zero_level,
   // Signal input seen by the receiver
   output logic                  signal_input_level,
   // Signal-input pin
   input  wire logic             signal_input_pin_level_in,
   output logic                  signal_input_pin_level_out,
   output logic                  signal_input_pin_drive_en,
   // Clock-output pin
   input  wire logic             clock_output_pin_level_in,
   output logic                  clock_output_pin_level_out,
   output logic                  clock_output_pin_drive_en,
   // Host select pin one
   input  wire logic             host_select_pin_one_level_in,
   output logic                  host_select_pin_one_level_out,
   output logic                  host_select_one_drive_en,
   // Host select pin zero
   input  wire logic             host_select_pin_zero_level_in,
   output logic                  host_select_pin_zero_level_out,
   output logic                  host_select_zero_drive_en,
   // Scan pins, bit 3 TCK down to bit 0 TDO
   input  wire logic [3:0]       scan_pin_level_in,
   output logic      [3:0]       scan_pin_level_out,
   output logic      [3:0]       scan_pin_drive_en
);

   import spare_pin_pkg::*;

   localparam int IDX_W = ADR_W - 2;

   // Bus state
   bus_state_e       bus_state_ff;
   bus_state_e       nxt_bus_state;
   logic             ack_ff;
   logic             err_ff;
   logic [31:0]      rdata_ff;
   logic [31:0]      nxt_rdata;
   logic             nxt_err;

   // Decode
   logic [IDX_W-1:0] reg_idx;
   logic             hit_enable;
   logic             hit_value;
   logic             hit_level;
   logic             hit_status;
   logic             hit_any;
   logic             bus_req;
   logic             wr_commit;

   // Registers and pin views
   logic [7:0]       pin_output_enable;
   logic [7:0]       pin_output_value;
   logic [7:0]       pin_input_level;
   logic [7:0]       effective_en;
   logic             scan_active_ff;
   logic [7:0]       func_oe;
   logic [7:0]       func_out;
   logic [7:0]       pad_in;
   logic [7:0]       pad_out;
   logic [7:0]       pad_oe;

   // ------------------------------------------------------------------
   // Wishbone decode
   // ------------------------------------------------------------------
   assign bus_req    = wb_cyc_i & wb_stb_i;
   assign reg_idx    = wb_adr_i[ADR_W-1:2];
   assign hit_enable = (reg_idx == IDX_W'(PIN_OUTPUT_ENABLE_IDX));
   assign hit_value  = (reg_idx == IDX_W'(PIN_OUTPUT_VALUE_IDX));
   assign hit_level  = (reg_idx == IDX_W'(PIN_INPUT_LEVEL_IDX));
   assign hit_status = (reg_idx == IDX_W'(PIN_DRIVE_STATUS_IDX));
   assign hit_any    = hit_enable | hit_value | hit_level | hit_status;

   // Writes land on the edge where the master samples the answer
   assign wr_commit = bus_req & wb_we_i & wb_sel_i[0] & ack_ff;

   // One idle cycle before the answer, then one cycle of answer,
   // then wait for the master to release the strobe.
   always_comb begin
      nxt_bus_state = bus_state_ff;
      case (bus_state_ff)
         BUS_IDLE: begin
            if (bus_req) begin
               nxt_bus_state = BUS_ACK;
            end
         end
         BUS_ACK: begin
            nxt_bus_state = BUS_DONE;
         end
         BUS_DONE: begin
            if (!bus_req) begin
               nxt_bus_state = BUS_IDLE;
            end
         end
         default: begin
            nxt_bus_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_state_ff <= BUS_IDLE;
      end else begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   // Mapped addresses answer with ack, anything else with err
   assign nxt_err = ~hit_any;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ack_ff <= (bus_state_ff == BUS_IDLE) & bus_req & ~nxt_err;
         err_ff <= (bus_state_ff == BUS_IDLE) & bus_req & nxt_err;
      end
   end

   // Read mux; unused upper bits read as zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (hit_enable) begin
         nxt_rdata[7:0] = pin_output_enable;
      end else if (hit_value) begin
         nxt_rdata[7:0] = pin_output_value;
      end else if (hit_level) begin
         nxt_rdata[7:0] = pin_input_level;
      end else if (hit_status) begin
         nxt_rdata[7:0] = effective_en;
         nxt_rdata[SCAN_ACTIVE_BIT] = scan_active_ff;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= 32'h0000_0000;
      end else if ((bus_state_ff == BUS_IDLE) & bus_req & ~wb_we_i) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_err_o = err_ff;
   assign wb_dat_o = rdata_ff;

   // ------------------------------------------------------------------
   // Software registers; the input-level and status words ignore writes
   // ------------------------------------------------------------------
   gpio_reg8 #(
      .RESET_VALUE (PIN_OUTPUT_ENABLE_RST)
   ) u_enable_reg (
      .clk      (clk),
      .rstn     (rstn),
      .wr_en    (wr_commit & hit_enable),
      .wr_data  (wb_dat_i[7:0]),
      .value_ff (pin_output_enable)
   );

   gpio_reg8 #(
      .RESET_VALUE (PIN_OUTPUT_VALUE_RST)
   ) u_value_reg (
      .clk      (clk),
      .rstn     (rstn),
      .wr_en    (wr_commit & hit_value),
      .wr_data  (wb_dat_i[7:0]),
      .value_ff (pin_output_value)
   );

   // ------------------------------------------------------------------
   // Scan activation level, held stable for the pin muxes
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scan_active_ff <= 1'b0;
      end else begin
         scan_active_ff <= scan_active;
      end
   end

   // Scan pins belong to the scan interface while scan is active,
   // whatever software wrote into the low enable bits.
   assign effective_en = pin_output_enable & ~(scan_active_ff ? SCAN_PIN_MASK : 8'h00);

   // ------------------------------------------------------------------
   // Normal pin functions when general-purpose drive is off
   // ------------------------------------------------------------------
   always_comb begin
      func_oe  = 8'h00;
      func_out = 8'h00;
      // Clock output runs only while its GPIO bit is clear
      func_oe[CLOCK_OUTPUT_BIT]  = clock_out_fn_en & ~pin_output_enable[CLOCK_OUTPUT_BIT];
      func_out[CLOCK_OUTPUT_BIT] = clock_out_fn;
      // Only TDO is an output of the scan interface
      func_oe[SCAN_TDO_BIT]  = scan_active_ff & scan_tdo_en;
      func_out[SCAN_TDO_BIT] = scan_tdo;
   end

   assign pad_in = {signal_input_pin_level_in,
                    clock_output_pin_level_in,
                    host_select_pin_one_level_in,
                    host_select_pin_zero_level_in,
                    scan_pin_level_in};

   // One cell per pin, same bit order in every register
   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      spare_pin_cell u_cell (
         .clk        (clk),
         .rstn       (rstn),
         .gpio_en    (effective_en[i]),
         .gpio_val   (pin_output_value[i]),
         .func_oe    (func_oe[i]),
         .func_out   (func_out[i]),
         .pad_in     (pad_in[i]),
         .pad_out_ff (pad_out[i]),
         .pad_oe_ff  (pad_oe[i]),
         .level_ff   (pin_input_level[i])
      );
   end

   // ------------------------------------------------------------------
   // Pad outputs
   // ------------------------------------------------------------------
   assign signal_input_pin_level_out     = pad_out[SIGNAL_INPUT_BIT];
   assign signal_input_pin_drive_en      = pad_oe[SIGNAL_INPUT_BIT];
   assign clock_output_pin_level_out     = pad_out[CLOCK_OUTPUT_BIT];
   assign clock_output_pin_drive_en      = pad_oe[CLOCK_OUTPUT_BIT];
   assign host_select_pin_one_level_out  = pad_out[HOST_SEL_ONE_BIT];
   assign host_select_one_drive_en       = pad_oe[HOST_SEL_ONE_BIT];
   assign host_select_pin_zero_level_out = pad_out[HOST_SEL_ZERO_BIT];
   assign host_select_zero_drive_en      = pad_oe[HOST_SEL_ZERO_BIT];
   assign scan_pin_level_out             = pad_out[SCAN_TCK_BIT:SCAN_TDO_BIT];
   assign scan_pin_drive_en              = pad_oe[SCAN_TCK_BIT:SCAN_TDO_BIT];

   // Levels for the internal users; one cycle behind the pads
   assign signal_input_level     = pin_input_level[SIGNAL_INPUT_BIT];
   assign host_select_one_level  = pin_input_level[HOST_SEL_ONE_BIT];
   assign host_select_zero_level = pin_input_level[HOST_SEL_ZERO_BIT];
   assign scan_tck               = pin_input_level[SCAN_TCK_BIT];
   assign scan_tms               = pin_input_level[SCAN_TMS_BIT];
   assign scan_tdi               = pin_input_level[SCAN_TDI_BIT];

endmodule : spare_pin_gpio_control

// ---- core/spare_pin_pkg.sv ----
// Constants for the spare pin general-purpose I/O block.
package spare_pin_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] PIN_OUTPUT_ENABLE_IDX = 8'h44;
   localparam logic [7:0] PIN_OUTPUT_VALUE_IDX  = 8'h45;
   localparam logic [7:0] PIN_INPUT_LEVEL_IDX   = 8'h46;
   localparam logic [7:0] PIN_DRIVE_STATUS_IDX  = 8'h7E;

   // Reset values
   localparam logic [7:0] PIN_OUTPUT_ENABLE_RST = 8'h00;
   localparam logic [7:0] PIN_OUTPUT_VALUE_RST  = 8'h00;

   // Bit positions, common to every pin register; SCAN_ACTIVE_BIT is in the status word only
   localparam int SIGNAL_INPUT_BIT = 7;
   localparam int CLOCK_OUTPUT_BIT = 6;
   localparam int HOST_SEL_ONE_BIT = 5;
   localparam int HOST_SEL_ZERO_BIT = 4;
   localparam int SCAN_TCK_BIT      = 3;
   localparam int SCAN_TMS_BIT      = 2;
   localparam int SCAN_TDI_BIT      = 1;
   localparam int SCAN_TDO_BIT      = 0;
   localparam int SCAN_ACTIVE_BIT   = 8;

   // Pins handed to the scan interface while scan is active
   localparam logic [7:0] SCAN_PIN_MASK = 8'h0F;

   localparam int PIN_COUNT = 8;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ACK,
      BUS_DONE
   } bus_state_e;

endpackage : spare_pin_pkg

// ---- sim/spare_pin_board.sv ----
// Board-side model of the eight spare pads.
`timescale 1ns/1ns
module spare_pin_board (
   // Device drive
   input  wire logic [7:0] drive_en,
   input  wire logic [7:0] drive_val,
   // Weak board levels, seen only where the device lets go
   input  wire logic [7:0] board_val,
   // Resolved pads
   output logic      [7:0] pad
);
   assign pad = (drive_en & drive_val) | (~drive_en & board_val);
endmodule : spare_pin_board

// ---- sim/spare_pin_gpio_control_checker.sv ----
// Assertions on the spare pin block's register bus and pad drive.
`timescale 1ns/1ns
module spare_pin_gpio_control_checker
   import spare_pin_pkg::*;
#(
   parameter int ADR_W = 12
) (
   input wire logic             clk,
   input wire logic             rstn,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic             wb_ack_o,
   input wire logic             wb_err_o,
   input wire logic             clock_out_fn_en,
   input wire logic             scan_active,
   input wire logic             signal_input_pin_level_out,
   input wire logic             signal_input_pin_drive_en,
   input wire logic             clock_output_pin_drive_en,
   input wire logic             host_select_one_drive_en,
   input wire logic [3:0]       scan_pin_drive_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_req;
      $rose(wb_cyc_i && wb_stb_i);
   endsequence
   sequence s_wr(logic [7:0] idx);
      wb_ack_o && wb_we_i && wb_sel_i[0] && (wb_adr_i[ADR_W-1:2] == idx);
   endsequence
   property p_answer; s_req |=> (wb_ack_o != wb_err_o); endproperty
   a_answer: assert property (p_answer) else $error("no single answer to request");
   property p_unmapped;
      ($rose(wb_cyc_i && wb_stb_i) && !(wb_adr_i[ADR_W-1:2] inside {8'h44, 8'h45, 8'h46, 8'h7E})) |=> wb_err_o;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_pulse; (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o); endproperty
   a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
   property p_sig_en; s_wr(PIN_OUTPUT_ENABLE_IDX) |=> ##1 signal_input_pin_drive_en == $past(wb_dat_i[7], 2); endproperty
   a_sig_en: assert property (p_sig_en) else $error("signal pin enable wrong");
   property p_sel_one; s_wr(PIN_OUTPUT_ENABLE_IDX) |=> ##1 host_select_one_drive_en == $past(wb_dat_i[5], 2); endproperty
   a_sel_one: assert property (p_sel_one) else $error("select one enable wrong");
   property p_scan_en;
      (s_wr(PIN_OUTPUT_ENABLE_IDX) ##0 !scan_active) ##1 !scan_active |-> ##1 scan_pin_drive_en[3:1] == $past(wb_dat_i[3:1], 2);
   endproperty
   a_scan_en: assert property (p_scan_en) else $error("scan pin enables wrong");
   property p_scan_off; $past(scan_active, 2) |-> scan_pin_drive_en[3:1] == 3'h0; endproperty
   a_scan_off: assert property (p_scan_off) else $error("scan pins driven during scan");
   property p_clk_fn; ($past(rstn) && $past(clock_out_fn_en)) |-> clock_output_pin_drive_en; endproperty
   a_clk_fn: assert property (p_clk_fn) else $error("clock pin not driven");
   property p_value;
      (s_wr(PIN_OUTPUT_VALUE_IDX) ##0 signal_input_pin_drive_en) ##1 signal_input_pin_drive_en
         |-> ##1 signal_input_pin_level_out == $past(wb_dat_i[7], 2);
   endproperty
   a_value: assert property (p_value) else $error("signal pin level wrong");
   property p_off; !signal_input_pin_drive_en |-> !signal_input_pin_level_out; endproperty
   a_off: assert property (p_off) else $error("disabled pin level not low");
endmodule : spare_pin_gpio_control_checker
bind spare_pin_gpio_control spare_pin_gpio_control_checker #(.ADR_W(ADR_W)) u_checker (
   .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o,
   .clock_out_fn_en, .scan_active, .signal_input_pin_level_out, .signal_input_pin_drive_en,
   .clock_output_pin_drive_en, .host_select_one_drive_en, .scan_pin_drive_en);

// ---- sim/spare_pin_gpio_control_test.sv ----
// Register-level testbench for the spare pin block.
`timescale 1ns/1ns
module spare_pin_gpio_control_test;
   import spare_pin_pkg::*;
   localparam logic [11:0] ENA = 12'h110, VAL = 12'h114, INL = 12'h118, STA = 12'h1F8;
   logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, e;
   logic [11:0] adr = 12'h000;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic        ack, err, fn = 1'b0, fn_en = 1'b0, scan = 1'b0;
   logic        tdo = 1'b0, tdo_en = 1'b0;
   logic [5:0]  lvl;
   logic [3:0]  lane = 4'h1;
   logic [7:0]  drv_en, drv_val, pad, ext = 8'hFF;
   int          failures = 0, n_tests = 0, cycles = 0;
   always #4 clk = ~clk;
   spare_pin_board board (.drive_en(drv_en), .drive_val(drv_val), .board_val(ext), .pad(pad));
   spare_pin_gpio_control dut (
      .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .clock_out_fn(fn),
      .clock_out_fn_en(fn_en), .scan_active(scan), .scan_tdo(tdo), .scan_tdo_en(tdo_en), .scan_tck(lvl[2]),
      .scan_tms(lvl[1]), .scan_tdi(lvl[0]), .host_select_one_level(lvl[4]), .host_select_zero_level(lvl[3]),
      .signal_input_level(lvl[5]),
      .signal_input_pin_level_in(pad[7]), .signal_input_pin_level_out(drv_val[7]), .signal_input_pin_drive_en(drv_en[7]),
      .clock_output_pin_level_in(pad[6]), .clock_output_pin_level_out(drv_val[6]), .clock_output_pin_drive_en(drv_en[6]),
      .host_select_pin_one_level_in(pad[5]), .host_select_pin_one_level_out(drv_val[5]),
      .host_select_one_drive_en(drv_en[5]), .host_select_pin_zero_level_in(pad[4]),
      .host_select_pin_zero_level_out(drv_val[4]), .host_select_zero_drive_en(drv_en[4]),
      .scan_pin_level_in(pad[3:0]), .scan_pin_level_out(drv_val[3:0]), .scan_pin_drive_en(drv_en[3:0]));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   // Classic single cycle; waits for ack or err with a bound
   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= lane; dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      q = dat_o;
      e = err;
      if (n >= 50) failures++;
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, ENA, 8'h00); check("enable reset", q, 32'h0);
      wb(1'b0, VAL, 8'h00); check("value reset", q, 32'h0);
      wb(1'b1, VAL, 8'h5A); wb(1'b0, VAL, 8'h00); check("value readback", q, 32'h5A);
      wb(1'b1, ENA, 8'hB0);
      settle(6);
      check("drive enables", drv_en, 8'hB0);
      check("driven levels", drv_val & drv_en, 8'h10);
      check("level outputs", lvl, 6'h0F);
      wb(1'b0, INL, 8'h00); check("input levels", q, 32'h5F);
      wb(1'b1, INL, 8'h00); wb(1'b0, INL, 8'h00); check("input read only", q, 32'h5F);
      wb(1'b1, VAL, 8'hDA);
      settle(3);
      check("signal pin level", drv_val[7], 1'b1);
      // Write without the low byte lane must leave the value alone
      lane = 4'h2;
      wb(1'b1, VAL, 8'h00);
      lane = 4'h1;
      wb(1'b0, VAL, 8'h00); check("masked write", q, 32'hDA);
      fn_en <= 1'b1;
      fn <= 1'b1;
      settle(3);
      check("clock function", {drv_en[6], drv_val[6]}, 2'b11);
      // Clock function held low so a GPIO high is distinguishable
      fn <= 1'b0;
      wb(1'b1, ENA, 8'h4F);
      settle(3);
      check("gpio enables", drv_en, 8'h4F);
      check("gpio levels", drv_val & drv_en, 8'h4A);
      scan <= 1'b1;
      tdo <= 1'b1;
      tdo_en <= 1'b1;
      settle(4);
      check("scan overrides", drv_en[3:1], 3'h0);
      check("scan drives tdo", {drv_en[0], drv_val[0]}, 2'b11);
      wb(1'b0, ENA, 8'h00); check("enable kept", q, 32'h4F);
      wb(1'b0, STA, 8'h00); check("drive status", q, 32'h140);
      scan <= 1'b0;
      tdo_en <= 1'b0;
      fn_en <= 1'b0;
      wb(1'b1, ENA, 8'h00);
      settle(3);
      check("all off", drv_en, 8'h00);
      wb(1'b0, 12'h200, 8'h00); check("unmapped err", e, 1'b1);
      // Second reset in mid-run: registers and drivers return to idle
      wb(1'b1, VAL, 8'hFF);
      wb(1'b1, ENA, 8'hF0);
      rstn <= 1'b0;
      settle(2);
      check("reset drivers", {drv_en, drv_val}, 16'h0000);
      rstn <= 1'b1;
      wb(1'b0, VAL, 8'h00); check("value after reset", q, 32'h0);
      wb(1'b0, ENA, 8'h00); check("enable after reset", q, 32'h0);
      finish_test();
   end
endmodule : spare_pin_gpio_control_test
